/* File: src/sar_ctrl_pkg.sv */
// package: constants and carrier types for the converter control block
package sar_ctrl_pkg;
    // result width and clock rate
    localparam int RESULT_W = 16;
    localparam int CLK_MHZ = 40;
    // longest conversion time in ns, rounded down to cycles
    localparam int CONV_MAX_NS = 527;
    localparam int CONV_CYCLES = (CONV_MAX_NS * CLK_MHZ) / 1000;
    // settle time after power-on reset in ns (host obeys it)
    localparam int POR_SETTLE_NS = 20000;
    localparam int POR_SETTLE_CYCLES = (POR_SETTLE_NS * CLK_MHZ) / 1000;
    // reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [4:0] CNT_RST = 5'h00;

    // synchronised pin levels
    typedef struct packed {
        logic convert_start;
        logic shift_clk;
        logic readout_enable_or_upstream;
        logic chain_sel;
    } pin_sync_t;

    // serial output pin as two signals: level and drive enable
    typedef struct packed {
        logic data;
        logic oe;
    } serial_pin_t;
endpackage : sar_ctrl_pkg

/* File: src/sar_result_reg.sv */
// result store: holds the last converted word, read data registered
`timescale 1ns/10ps
module sar_result_reg #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // write side
    input wire logic wr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // read side
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_r; // stored result
    logic [WIDTH-1:0] mem_nxt;

    // next value: replaced only at a conversion end
    always_comb begin
        mem_nxt = mem_r;
        if (wr_in) begin
            mem_nxt = wr_data_in;
        end
    end

    // register
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_r <= WIDTH'(sar_ctrl_pkg::RESULT_RST);
        end else if (clk_en_in) begin
            mem_r <= mem_nxt;
        end
    end

    assign rd_data_out = mem_r;
endmodule : sar_result_reg

/* File: src/sar_adc_ctrl.sv */
// converter control: conversion sequencing, busy, serial readout, chain
//
// Function
// - rising start edge begins conversion, powers core
// - start edges ignored while converting
// - busy high throughout conversion, low after
// - auto power-down and acquire after conversion
// - conversion completes within 527 ns
// - reset at power-up and supply drop
// - last result readable while powered down
// - shift only with clock and enabled output
// - output changes on rising shift-clock edge
// - msb valid until first rising edge
// - chain select low gives normal mode
// - normal mode: enable high floats output
// - msb appears at busy falling edge
// - enable low presents msb at once
// - chain select high: always driven, upstream input
// - shift out msb first on rising edges
// - result is straight binary
`timescale 1ns/10ps
module sar_adc_ctrl #(
    parameter int WIDTH = 16,
    parameter int CONV_CYCLES = sar_ctrl_pkg::CONV_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // host pins
    input wire logic convert_start_in,
    input wire logic shift_clk_in,
    input wire logic readout_enable_or_upstream_in,
    input wire logic chain_sel_in,
    // converter core
    input wire logic [WIDTH-1:0] sar_code_in,
    output logic core_power_out,
    output logic sample_hold_out,
    // status and serial output
    output logic busy_out,
    output logic serial_data_out,
    output logic serial_data_oe_out
);
    ////////////////////////////////////////////////////////////////////
    // input synchronisers: two flops on every pin
    sar_ctrl_pkg::pin_sync_t meta_r; // first stage, read only by sync_r
    sar_ctrl_pkg::pin_sync_t sync_r; // second stage
    sar_ctrl_pkg::pin_sync_t prev_r; // for edge finding
    sar_ctrl_pkg::pin_sync_t pins_now;

    always_comb begin
        pins_now.convert_start = convert_start_in;
        pins_now.shift_clk = shift_clk_in;
        pins_now.readout_enable_or_upstream = readout_enable_or_upstream_in;
        pins_now.chain_sel = chain_sel_in;
    end

    // sync register chain
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else if (clk_en_in) begin
            meta_r <= pins_now;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic start_rise; // start edge seen
    logic sck_rise; // shift clock rising edge seen
    logic chain_mode; // high selects daisy chain
    assign start_rise = sync_r.convert_start & ~prev_r.convert_start;
    assign sck_rise = sync_r.shift_clk & ~prev_r.shift_clk;
    assign chain_mode = sync_r.chain_sel;

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer
    typedef enum logic [0:0] {ST_ACQUIRE, ST_CONVERT} conv_state_t;
    conv_state_t state_r, state_nxt;
    logic [15:0] conv_cnt_r, conv_cnt_nxt; // cycles left in conversion
    logic conv_done; // one-cycle end of conversion
    logic [WIDTH-1:0] stored_result; // last result from store

    // next state
    always_comb begin
        state_nxt = state_r;
        conv_cnt_nxt = conv_cnt_r;
        conv_done = 1'b0;
        unique case (state_r)
            ST_ACQUIRE: begin
                if (start_rise) begin
                    state_nxt = ST_CONVERT;
                    conv_cnt_nxt = 16'(CONV_CYCLES - 1);
                end
            end
            ST_CONVERT: begin
                // start edges ignored here
                if (conv_cnt_r == 16'h0000) begin
                    state_nxt = ST_ACQUIRE;
                    conv_done = 1'b1;
                end else begin
                    conv_cnt_nxt = conv_cnt_r - 16'h0001;
                end
            end
        endcase
    end

    // register; reset covers power-up and supply drop
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ST_ACQUIRE;
            conv_cnt_r <= 16'(sar_ctrl_pkg::CNT_RST);
        end else if (clk_en_in) begin
            state_r <= state_nxt;
            conv_cnt_r <= conv_cnt_nxt;
        end
    end

    // result store: straight binary code kept as delivered
    sar_result_reg #(.WIDTH(WIDTH)) u_store (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .clk_en_in(clk_en_in),
        .wr_in(conv_done),
        .wr_data_in(sar_code_in),
        .rd_data_out(stored_result)
    );

    ////////////////////////////////////////////////////////////////////
    // serial shifter
    logic [WIDTH-1:0] shift_r, shift_nxt; // outgoing bits, msb at top
    logic load_pend_r, load_pend_nxt; // store just written, shifter must match it
    logic busy_r, busy_nxt;
    logic power_r, power_nxt;
    sar_ctrl_pkg::serial_pin_t pin_r, pin_nxt;

    // next values for shifter and outputs
    always_comb begin
        shift_nxt = shift_r;
        load_pend_nxt = conv_done;
        busy_nxt = (state_nxt == ST_CONVERT);
        power_nxt = (state_nxt == ST_CONVERT);
        if (conv_done) begin
            // taken straight from the core so the msb stands as busy falls
            shift_nxt = sar_code_in;
        end else if (sck_rise && (chain_mode || !sync_r.readout_enable_or_upstream)) begin
            // shift only when clocked and enabled works in power-down
            shift_nxt = {shift_r[WIDTH-2:0],
                         chain_mode & sync_r.readout_enable_or_upstream};
        end
        pin_nxt.data = shift_nxt[WIDTH-1];
        pin_nxt.oe = chain_mode | ~sync_r.readout_enable_or_upstream;
    end

    // register
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_r <= WIDTH'(sar_ctrl_pkg::RESULT_RST);
            load_pend_r <= 1'b0;
            busy_r <= 1'b0;
            power_r <= 1'b0;
            pin_r <= '0;
        end else if (clk_en_in) begin
            shift_r <= shift_nxt;
            load_pend_r <= load_pend_nxt;
            busy_r <= busy_nxt;
            power_r <= power_nxt;
            pin_r <= pin_nxt;
        end
    end

    // busy drops together with msb being presented
    assign busy_out = busy_r;
    assign core_power_out = power_r;
    assign sample_hold_out = power_r;
    assign serial_data_out = pin_r.data;
    assign serial_data_oe_out = pin_r.oe;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_busy_len: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ($rose(busy_r) && clk_en_in) |-> busy_r [*2])
        else $error("busy too short");
    a_start_conv: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && start_rise && state_r == ST_ACQUIRE) |=> busy_r)
        else $error("start edge missed");
    // bound is the conversion length; holds only while the enable stays high
    a_conv_ends: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        $rose(busy_r) |-> ##[1:CONV_CYCLES] !busy_r)
        else $error("conversion too long");
    a_no_restart: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && state_r == ST_CONVERT && conv_cnt_r != 16'h0000)
        |=> state_r == ST_CONVERT)
        else $error("conversion restarted");
    // shifter and store took the same word at the conversion end
    a_load_msb: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        load_pend_r |-> shift_r == stored_result)
        else $error("shifter and store differ");
    a_msb_at_fall: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        $fell(busy_r) |-> serial_data_out == stored_result[WIDTH-1])
        else $error("msb late at busy fall");
    a_oe_mode: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && !chain_mode)
        |=> serial_data_oe_out == !$past(sync_r.readout_enable_or_upstream))
        else $error("output enable wrong");
    a_oe_chain: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && chain_mode) |=> serial_data_oe_out)
        else $error("chain output not driven");
    a_hold_msb: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && !sck_rise && !conv_done) |=> $stable(shift_r))
        else $error("shift without edge");
    a_chain_in: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        (clk_en_in && sck_rise && chain_mode && !conv_done)
        |=> shift_r[0] == $past(sync_r.readout_enable_or_upstream))
        else $error("chain bit lost");
    a_power_down: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        $fell(busy_r) |-> !core_power_out)
        else $error("no power down");
endmodule : sar_adc_ctrl

/* File: verif/sar_host_model.sv */
// host side model: drives start, shift clock and the enable or upstream pin
`timescale 1ns/10ps
module sar_host_model (
    // clock
    input wire logic ref_clk_in,
    // pins toward the device
    output logic convert_start_out,
    output logic shift_clk_out,
    output logic sel_data_out,
    // serial line seen back
    input wire logic serial_data_in
);
    // pins idle low, shift clock parked between frames
    initial begin
        convert_start_out = 1'b0;
        shift_clk_out = 1'b0;
        sel_data_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one start pulse; high for one cycle so its fall lands early
    task automatic pulse_start();
        @(posedge ref_clk_in);
        convert_start_out <= 1'b1;
        @(posedge ref_clk_in);
        convert_start_out <= 1'b0;
    endtask : pulse_start
    // enable level in normal mode, data level in chain mode
    task automatic set_sel(input logic v);
        @(posedge ref_clk_in);
        sel_data_out <= v;
    endtask : set_sel
    // n shift clocks of 200 ns, far slower than the part allows, since the
    // sampling clock must see every level; throughput is not the aim here
    // bit read just before each rise; call only on a clock edge
    task automatic shift(input int n, input logic [31:0] up, output logic [31:0] got);
        got = 32'h00000000;
        for (int i = 0; i < n; i++) begin
            sel_data_out <= up[31 - i]; // upstream bit set up before the rise
            repeat (4) @(posedge ref_clk_in);
            got = {got[30:0], serial_data_in};
            shift_clk_out <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            shift_clk_out <= 1'b0;
        end
    endtask : shift
endmodule : sar_host_model

/* File: verif/tb_sar_adc_conversion_and_serial_readout.sv */
// bench: conversion, readout, enable, chain and reset scenarios
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sar_adc_conversion_and_serial_readout;
    // clock, reset, bench-driven pins
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic chain_sel = 1'b0;
    logic [15:0] code = 16'h0000;
    // host pins and device outputs
    wire logic start_pin, sck, sel, busy, ser_out, oe, pwr, sh;
    wire logic line_seen; // serial line as the host sees it
    int n_errors = 0;
    int n_tests = 0;
    int blen = 0; // cycles seen with busy high
    logic [31:0] bits;
    always #12.5 ref_clk_in = ~ref_clk_in;
    // busy length counter
    always @(posedge ref_clk_in) if (busy === 1'b1) blen <= blen + 1;
    // a released line has no pull here: the host sees the inverse of the held bit
    assign line_seen = oe ? ser_out : ~ser_out;
    sar_host_model host_u (.ref_clk_in(ref_clk_in), .convert_start_out(start_pin),
        .shift_clk_out(sck), .sel_data_out(sel), .serial_data_in(line_seen));
    sar_adc_ctrl dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .clk_en_in(1'b1),
        .convert_start_in(start_pin), .shift_clk_in(sck), .readout_enable_or_upstream_in(sel),
        .chain_sel_in(chain_sel), .sar_code_in(code), .core_power_out(pwr),
        .sample_hold_out(sh), .busy_out(busy), .serial_data_out(ser_out),
        .serial_data_oe_out(oe));
    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    // bounded wait ran out
    task automatic fail();
        n_errors++;
        close_out();
    endtask : fail
    // one conversion; twice adds a start edge while busy
    task automatic convert(input logic [15:0] c, input bit twice);
        int n;
        @(posedge ref_clk_in);
        code <= c;
        blen <= 0;
        host_u.pulse_start();
        n = 0;
        while (busy !== 1'b1) begin
            @(posedge ref_clk_in);
            n++;
            if (n > 8) fail();
        end
        `CHK(pwr, 1'b1)
        `CHK(sh, 1'b1)
        if (twice) host_u.pulse_start();
        n = 0;
        while (busy !== 1'b0) begin
            @(posedge ref_clk_in);
            n++;
            if (n > 40) fail();
        end
        `CHK(blen, sar_ctrl_pkg::CONV_CYCLES)
        `CHK(ser_out, c[15])
        repeat (3) @(posedge ref_clk_in);
        `CHK(pwr, 1'b0)
        `CHK(sh, 1'b0)
        `CHK(ser_out, c[15])
        repeat (20) @(posedge ref_clk_in);
    endtask : convert
    // readout after power-down, msb first, straight binary
    task automatic test_readout();
        convert(16'h5A3C, 1'b0);
        host_u.shift(16, 32'h00000000, bits);
        `CHK(bits[15:0], 16'h5A3C)
        $display("test readout done");
    endtask : test_readout
    // enable high floats, enable low drives msb at once
    task automatic test_enable();
        convert(16'h8001, 1'b0);
        host_u.set_sel(1'b1);
        repeat (5) @(posedge ref_clk_in);
        `CHK(oe, 1'b0)
        // clock while disabled: the msb must still be there afterwards
        host_u.shift(4, 32'hFFFFFFFF, bits);
        host_u.set_sel(1'b0);
        repeat (5) @(posedge ref_clk_in);
        `CHK(oe, 1'b1)
        `CHK(ser_out, 1'b1)
        $display("test enable done");
    endtask : test_enable
    // chain: always driven, upstream word follows own result
    task automatic test_chain();
        chain_sel <= 1'b1;
        host_u.set_sel(1'b1);
        repeat (5) @(posedge ref_clk_in);
        `CHK(oe, 1'b1)
        convert(16'h3C5A, 1'b0);
        host_u.shift(32, 32'hF00F0000, bits);
        `CHK(bits, 32'h3C5AF00F)
        chain_sel <= 1'b0;
        host_u.set_sel(1'b0);
        $display("test chain done");
    endtask : test_chain
    // reset mid-conversion clears busy and output drive
    task automatic test_reset();
        host_u.pulse_start();
        repeat (6) @(posedge ref_clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        `CHK(busy, 1'b0)
        `CHK(oe, 1'b0)
        resetn_in <= 1'b1;
        repeat (sar_ctrl_pkg::POR_SETTLE_CYCLES) @(posedge ref_clk_in);
        convert(16'hFFFF, 1'b0);
        $display("test reset done");
    endtask : test_reset
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        repeat (sar_ctrl_pkg::POR_SETTLE_CYCLES) @(posedge ref_clk_in);
        convert(16'hA5C3, 1'b1);
        $display("test refused start done");
        test_readout();
        test_enable();
        test_chain();
        test_reset();
        close_out();
    end
endmodule : tb_sar_adc_conversion_and_serial_readout
